// ### rtl/bms_boot_select.v
// Boot mode selector: samples the strap pins after reset.
// What this block does
// - After each reset, sample straps and pick boot action before user code.
// - First pin high selects flash entry, other pins ignored.
// - First low, second high selects the serial EEPROM loader.
// - Pins 0,0,1,1 select the asynchronous serial port loader.
// - Pins 0,0,1,0 jump to the upper SRAM block entry.
// - Pins 0,0,0,1 jump to the one-time-programmable memory entry.
// - All pins low select the parallel port loader.
// - Flash, SRAM and OTP choices load no external code.
// - Only the first pin has a pull-up; the board drives others.
// - OTP region spans one 1K x 16 window from its entry.
`timescale 1ns/10ps
module bms_boot_select
(
   ref_clk,
   rst,
   boot_sel_pin_first,
   boot_sel_pin_first_driven,
   boot_sel_pin_second,
   boot_sel_pin_third,
   boot_sel_pin_fourth,
   boot_mode,
   boot_entry_addr,
   boot_loads_code,
   boot_done,
   otp_base_addr,
   otp_last_addr
);
`include "bms_defs.vh"
parameter SETTLE = `BMS_SETTLE_CYCLES;
input wire ref_clk;
input wire rst;
input wire boot_sel_pin_first;
input wire boot_sel_pin_first_driven;
input wire boot_sel_pin_second;
input wire boot_sel_pin_third;
input wire boot_sel_pin_fourth;
output reg [`BMS_MODE_W-1:0] boot_mode;
output reg [`BMS_ADDR_W-1:0] boot_entry_addr;
output reg boot_loads_code;
output reg boot_done;
output wire [`BMS_ADDR_W-1:0] otp_base_addr;
output wire [`BMS_ADDR_W-1:0] otp_last_addr;

// ==========================================================
// States
localparam ST_SETTLE = 2'b01;
localparam ST_HOLD = 2'b10;

// Last count of the settle phase; SETTLE must be at least one.
localparam [`BMS_CNT_W-1:0] SETTLE_LAST = SETTLE[`BMS_CNT_W-1:0] - 1'b1;

// ==========================================================
// Internal signals
reg [1:0] state;
reg [1:0] next_state;
reg [`BMS_CNT_W-1:0] cnt;
reg [`BMS_CNT_W-1:0] next_cnt;
reg [`BMS_MODE_W-1:0] next_boot_mode;
reg [`BMS_ADDR_W-1:0] next_boot_entry_addr;
reg next_boot_loads_code;
reg next_boot_done;
wire pin_first_eff;
wire [`BMS_MODE_W-1:0] dec_mode;
wire [`BMS_ADDR_W-1:0] dec_addr;
wire dec_loads;
wire settle_end;

// ==========================================================
// Functions
// Saturating step, so a counter that is never cleared cannot wrap.
function [`BMS_CNT_W-1:0] cnt_step;
   input [`BMS_CNT_W-1:0] value;
   begin
      if (value == {`BMS_CNT_W{1'b1}})
      begin
         cnt_step = value;
      end
      else
      begin
         cnt_step = value + 1'b1;
      end
   end
endfunction

// An undriven first pin reads high through its pull-up.
assign pin_first_eff = boot_sel_pin_first | ~boot_sel_pin_first_driven;

// The OTP window is fixed, 1K words from its entry.
assign otp_base_addr = `BMS_ADDR_OTP;
assign otp_last_addr = `BMS_ADDR_OTP_END;

bms_decode u_dec
(
   .pin_first(pin_first_eff),
   .pin_second(boot_sel_pin_second),
   .pin_third(boot_sel_pin_third),
   .pin_fourth(boot_sel_pin_fourth),
   .mode(dec_mode),
   .entry_addr(dec_addr),
   .loads_code(dec_loads)
);

// ==========================================================
// Sampling sequencer, next values
// A few settle cycles let straps stabilise after reset; the serial clock
// pin may still be toggling then, which the board must tolerate.
assign settle_end = (cnt == SETTLE_LAST);

always @*
begin
   next_state = state;
   next_cnt = cnt;
   next_boot_mode = boot_mode;
   next_boot_entry_addr = boot_entry_addr;
   next_boot_loads_code = boot_loads_code;
   next_boot_done = boot_done;
   case (state)
      ST_SETTLE:
      begin
         if (settle_end)
         begin
            // Single capture per reset.
            next_boot_mode = dec_mode;
            next_boot_entry_addr = dec_addr;
            next_boot_loads_code = dec_loads;
            next_boot_done = 1'b1;
            next_state = ST_HOLD;
         end
         else
         begin
            next_cnt = cnt_step(cnt);
         end
      end
      ST_HOLD:
      begin
         // Later pin changes are ignored until reset.
         next_state = ST_HOLD;
      end
      default:
      begin
         // An illegal state restarts the settle phase.
         next_state = ST_SETTLE;
         next_cnt = {`BMS_CNT_W{1'b0}};
      end
   endcase
end

// ==========================================================
// Sampling sequencer, registers
always @(posedge ref_clk)
begin
   if (rst)
   begin
      state <= ST_SETTLE;
      cnt <= {`BMS_CNT_W{1'b0}};
      boot_mode <= `BMS_MODE_NONE;
      boot_entry_addr <= `BMS_ADDR_NONE;
      boot_loads_code <= 1'b0;
      boot_done <= 1'b0;
   end
   else
   begin
      state <= next_state;
      cnt <= next_cnt;
      boot_mode <= next_boot_mode;
      boot_entry_addr <= next_boot_entry_addr;
      boot_loads_code <= next_boot_loads_code;
      boot_done <= next_boot_done;
   end
end
endmodule

// ### rtl/bms_decode.v
// Combinational decoder from strap pins to boot mode and entry address.
`timescale 1ns/10ps
module bms_decode
(
   pin_first,
   pin_second,
   pin_third,
   pin_fourth,
   mode,
   entry_addr,
   loads_code
);
`include "bms_defs.vh"
input wire pin_first;
input wire pin_second;
input wire pin_third;
input wire pin_fourth;
output reg [`BMS_MODE_W-1:0] mode;
output reg [`BMS_ADDR_W-1:0] entry_addr;
output reg loads_code;

// ==========================================================
// Decode
always @*
begin
   mode = `BMS_MODE_PAR;
   entry_addr = `BMS_ADDR_NONE;
   loads_code = 1'b1;
   if (pin_first)
   begin
      // The other three pins are ignored here.
      mode = `BMS_MODE_FLASH;
      entry_addr = `BMS_ADDR_FLASH;
      loads_code = 1'b0;
   end
   else if (pin_second)
   begin
      mode = `BMS_MODE_SPI;
   end
   else
   begin
      case ({pin_third, pin_fourth})
         2'b11: mode = `BMS_MODE_UART;
         2'b10:
         begin
            mode = `BMS_MODE_SRAM;
            entry_addr = `BMS_ADDR_SRAM;
            loads_code = 1'b0;
         end
         2'b01:
         begin
            mode = `BMS_MODE_OTP;
            entry_addr = `BMS_ADDR_OTP;
            loads_code = 1'b0;
         end
         default: mode = `BMS_MODE_PAR;
      endcase
   end
end
endmodule

// ### rtl/bms_defs.vh
// Constants for the boot mode selector.
`ifndef BMS_DEFS_VH
`define BMS_DEFS_VH
// ==========================================================
// Mode codes, one-hot except BMS_MODE_NONE, which is zero
`define BMS_MODE_W 6
`define BMS_MODE_NONE 6'h00
`define BMS_MODE_FLASH 6'h01
`define BMS_MODE_SPI 6'h02
`define BMS_MODE_UART 6'h04
`define BMS_MODE_SRAM 6'h08
`define BMS_MODE_OTP 6'h10
`define BMS_MODE_PAR 6'h20
// ==========================================================
// Entry addresses
`define BMS_ADDR_W 22
`define BMS_ADDR_FLASH 22'h3f7ff6
`define BMS_ADDR_SRAM 22'h3f8000
`define BMS_ADDR_OTP 22'h3d7800
`define BMS_ADDR_OTP_END 22'h3d7bff
`define BMS_ADDR_NONE 22'h000000
// ==========================================================
// Sequencer
`define BMS_SETTLE_CYCLES 4'h4
`define BMS_CNT_W 4
`endif

// ### verification/bms_board.sv
// Board strapping model for the boot-select pins.
`timescale 1ns/10ps
module bms_board
(
   input wire [4:0] strap,
   output wire boot_sel_pin_first_driven,
   output wire boot_sel_pin_first,
   output wire boot_sel_pin_second,
   output wire boot_sel_pin_third,
   output wire boot_sel_pin_fourth
);
// ====================
// Straps
assign boot_sel_pin_first_driven = strap[4];
assign boot_sel_pin_first = strap[4] ? strap[3] : 1'b1;
assign boot_sel_pin_second = strap[2];
assign boot_sel_pin_third = strap[1];
assign boot_sel_pin_fourth = strap[0];
endmodule

// ### verification/bms_boot_select_assertions.sv
// Checker for the boot mode selector outputs.
`timescale 1ns/10ps
`include "bms_defs.vh"
module bms_chk
(
   input wire ref_clk,
   input wire rst,
   input wire [5:0] boot_mode,
   input wire [21:0] boot_entry_addr,
   input wire boot_loads_code,
   input wire boot_done,
   input wire [21:0] otp_base_addr,
   input wire [21:0] otp_last_addr
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
// ====================
// Properties
property p_hot;
   boot_done |-> $onehot(boot_mode);
endproperty
a_hot: assert property (p_hot)
   else $error("mode");
property p_idle;
   !boot_done |-> boot_mode == 6'h00;
endproperty
a_idle: assert property (p_idle)
   else $error("idle");
property p_time;
   $fell(rst) |-> !boot_done ##3 !boot_done ##1 boot_done;
endproperty
a_time: assert property (p_time)
   else $error("time");
property p_hold;
   $past(boot_done) && !$past(rst) |-> boot_done
      && $stable(boot_mode) && $stable(boot_entry_addr);
endproperty
a_hold: assert property (p_hold)
   else $error("hold");
property p_fl;
   boot_mode == `BMS_MODE_FLASH |-> boot_entry_addr == `BMS_ADDR_FLASH;
endproperty
a_fl: assert property (p_fl)
   else $error("flash");
property p_sr;
   boot_mode == `BMS_MODE_SRAM |-> boot_entry_addr == `BMS_ADDR_SRAM;
endproperty
a_sr: assert property (p_sr)
   else $error("sram");
property p_otp;
   boot_mode == `BMS_MODE_OTP |-> boot_entry_addr == `BMS_ADDR_OTP;
endproperty
a_otp: assert property (p_otp)
   else $error("otp");
property p_ld;
   boot_done |-> boot_loads_code ==
      |(boot_mode & (`BMS_MODE_SPI | `BMS_MODE_UART | `BMS_MODE_PAR));
endproperty
a_ld: assert property (p_ld)
   else $error("load");
property p_win;
   otp_base_addr == `BMS_ADDR_OTP
      && otp_last_addr - otp_base_addr == 22'h3ff;
endproperty
a_win: assert property (p_win)
   else $error("win");
endmodule
bind bms_boot_select bms_chk chk(.*);

// ### verification/tb.sv
// Self-checking bench for the boot mode selector.
`timescale 1ns/10ps
`include "bms_defs.vh"
module tb;
reg ref_clk = 0;
reg rst = 1;
reg [4:0] strap = 0;
reg [27:0] e;
integer seed = 32'hf6f4c709;
integer err_total = 0;
integer total_checks = 0;
integer i;
wire boot_sel_pin_first, boot_sel_pin_first_driven, boot_sel_pin_second;
wire boot_sel_pin_third, boot_sel_pin_fourth, boot_loads_code, boot_done;
wire [5:0] boot_mode;
wire [21:0] boot_entry_addr, otp_base_addr, otp_last_addr;
wire [27:0] got = {boot_mode, boot_entry_addr};
bms_board board(.*);
bms_boot_select uut(.*);
always #25 ref_clk = ~ref_clk;
// ====================
// Model and checks
function [27:0] model(input [4:0] s);
   begin
      if (!s[4] || s[3]) model = {`BMS_MODE_FLASH, `BMS_ADDR_FLASH};
      else if (s[2]) model = {`BMS_MODE_SPI, 22'h0};
      else if (s[1] && s[0]) model = {`BMS_MODE_UART, 22'h0};
      else if (s[1]) model = {`BMS_MODE_SRAM, `BMS_ADDR_SRAM};
      else if (s[0]) model = {`BMS_MODE_OTP, `BMS_ADDR_OTP};
      else model = {`BMS_MODE_PAR, 22'h0};
   end
endfunction
task chk(input [27:0] seen, input [27:0] exp, input string nm);
   begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   end
endtask
task results;
   begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
endtask
task run(input [4:0] v);
   begin
      @(posedge ref_clk) #1 rst = 1;
      strap = v;
      e = model(v);
      @(posedge ref_clk) #1 rst = 0;
      repeat (3) @(posedge ref_clk);
      #1 chk(boot_done, 0, "done");
      chk({boot_loads_code, got}, 28'h0, "idle");
      @(posedge ref_clk);
      #1 chk(got, e, "mode");
      chk(boot_done, 1, "done");
      chk(otp_base_addr, 22'h3d7800, "otp_base");
      chk(otp_last_addr, 22'h3d7bff, "otp_last");
      chk(boot_loads_code, |(e[27:22] & 6'h26), "loads");
      strap = ~v;
      repeat (2) @(posedge ref_clk);
      #1 chk({boot_done, got}, {1'b1, e}, "held");
      $display("strap %b ended", v);
   end
endtask
// ====================
// Sequence
initial
begin
   repeat (8) @(posedge ref_clk);
   for (i = 0; i < 32; i = i + 1)
      run(i);
   for (i = 0; i < 8; i = i + 1)
      run($random(seed));
   results;
end
initial
begin
   #100000;
   err_total = err_total + 1;
   results;
end
endmodule
